// ===== hw/jmipg_pkg.sv
// Constants and types for the link mode and alignment parameter generator
package jmipg_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_KM1 = 8'h04;
  localparam logic [7:0] ADDR_DID = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_PRM0 = 8'h14;
  localparam logic [7:0] ADDR_PRM1 = 8'h18;

  // Reset values
  localparam logic [4:0] MODE_RST = 5'h00;
  localparam logic [7:0] KM1_RST = 8'h1f;
  localparam logic [7:0] DID_RST = 8'h00;

  // Control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SCR_BIT = 1;
  localparam int CTRL_SEL_LSB = 4;

  // Status register fields
  localparam int STAT_DES_BIT = 0;
  localparam int STAT_BAD_BIT = 1;
  localparam int STAT_CAL_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;
  localparam int STAT_ENC_BIT = 4;
  localparam int STAT_R_LSB = 8;

  // Alignment sequence and FIFO constants
  localparam logic [3:0] ILAS_LAST_IDX = 4'hd;
  localparam logic [2:0] JESDV_VAL = 3'h1;
  localparam logic [2:0] SUBCLASS_VAL = 3'h1;
  localparam logic [7:0] E_VAL = 8'h01;
  localparam logic [1:0] LINKS_VAL = 2'h2;
  localparam logic [3:0] FIFO_DEPTH = 4'hf + 4'h1 == 4'h0 ? 4'h0 : 4'h0;
  localparam int FIFO_WORDS = 16;

  // Derived transport parameters of one link mode
  typedef struct packed {
    logic bad;
    logic enc64;
    logic des;
    logic [1:0] links;
    logic [4:0] n;
    logic [1:0] cs;
    logic [4:0] np;
    logic [3:0] l;
    logic [3:0] m;
    logic [3:0] f;
    logic [3:0] s;
    logic hd;
    logic [5:0] r8;
  } jmipg_prm_type;

  // One octet of an alignment configuration stream
  typedef struct packed {
    logic [3:0] lane;
    logic [3:0] idx;
    logic [7:0] octet;
  } jmipg_word_type;

  typedef enum logic [1:0] {GEN_IDLE, GEN_RUN, GEN_DONE} jmipg_gen_type;

endpackage

// ===== hw/jmipg_top.sv
// Link mode decoder, alignment parameter generator, FIFO and register slave
// Behaviour
// - Single-channel mode merges both channels: two samples per clock.
// - All transport parameters come from the link mode selection.
// - Dual-input interleaved: each channel samples its own input.
// - Dual-input mode keeps single-channel datapath and link behaviour.
// - Interleave flag reads 1 in single-channel, 0 in dual-channel.
// - R gives lane bits per clock; lane rate is clock times R.
// - K comes from the K-minus-one field; ignored in 64b/66b.
// - E is fixed at 1 in 64b/66b, ignored in 8b/10b.
// - 8b/10b sends parameters in alignment sequence; 64b/66b sends none.
// - ADJCNT, ADJDIR, BID, CF, HD, RES1, RES2 always sent zero.
// - Control bits per sample always sent as zero.
// - DID field carries the software device identifier.
// - JESDV and SUBCLASSV both sent as 1.
// - SCR field follows the software scrambler enable.
// - Checksum is the sum of the preceding fields modulo 256.
// - Each lane carries its own lane identifier.
// - M only defines bit packing, may differ from channel count.
//
// The AHB-Lite register port and the address map were chosen for this implementation.

module jmipg_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } jmipg_fst_type;

  jmipg_fst_type r;
  jmipg_fst_type n;
  logic push;
  logic pop;

  assign in_ready = r.cnt != (AW+1)'(DEPTH);
  assign out_valid = r.cnt != '0;
  assign out_data = r.mem[r.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wp] = in_data;
      n.wp = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + 1'b1;
    end
    if (push && !pop) begin
      n.cnt = r.cnt + 1'b1;
    end else if (pop && !push) begin
      n.cnt = r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end
endmodule

module jmipg_top #(
  parameter int FIFO_DEPTH = jmipg_pkg::FIFO_WORDS
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [11:0] smp_a,
  input wire logic [11:0] smp_b,
  input wire logic smp_valid,
  output logic [23:0] smp_out,
  output logic smp_out_valid,
  output logic smp_out_pair,
  input wire logic cal_done,
  output jmipg_pkg::jmipg_word_type ilas_word,
  output logic ilas_valid,
  input wire logic ilas_ready,
  output logic [5:0] lane_rate_x8,
  output logic link_active
);

  typedef struct packed {
    logic [4:0] mode;
    logic [7:0] km1;
    logic [7:0] did;
    logic link_en;
    logic scr_en;
    logic [1:0] in_sel;
    logic cal_needed;
    jmipg_pkg::jmipg_prm_type prm;
    jmipg_pkg::jmipg_prm_type l_prm;
    logic [7:0] l_km1;
    logic [7:0] l_did;
    logic l_scr;
    jmipg_pkg::jmipg_gen_type st;
    logic [3:0] lane;
    logic [3:0] idx;
    logic dph;
    logic dph_wr;
    logic [7:0] dph_addr;
    logic hreadyout;
    logic [31:0] hrdata;
    logic ob_valid;
    jmipg_pkg::jmipg_word_type ob_word;
    logic [23:0] so_data;
    logic so_valid;
    logic so_pair;
  } jmipg_st_type;

  jmipg_st_type r;
  jmipg_st_type n;
  logic f_in_valid;
  logic f_in_ready;
  jmipg_pkg::jmipg_word_type f_in_data;
  logic f_out_valid;
  logic f_out_ready;
  jmipg_pkg::jmipg_word_type f_out_data;

  function automatic jmipg_pkg::jmipg_prm_type mk(
    input logic des, input logic [3:0] l, input logic [3:0] m,
    input logic [3:0] f, input logic [3:0] s, input logic [4:0] nb,
    input logic [4:0] np, input logic [1:0] cs, input logic hd,
    input logic [5:0] r8);
    jmipg_pkg::jmipg_prm_type p;
    p = '0;
    p.des = des;
    p.links = jmipg_pkg::LINKS_VAL;
    p.l = l;
    p.m = m;
    p.f = f;
    p.s = s;
    p.n = nb;
    p.np = np;
    p.cs = cs;
    p.hd = hd;
    p.r8 = r8;
    return p;
  endfunction

  // R held in eighths so that 0.625 and 1.25 stay exact
  function automatic jmipg_pkg::jmipg_prm_type mode_table(
    input logic [4:0] sel);
    jmipg_pkg::jmipg_prm_type p;
    p = '0;
    case (sel)
      5'h00: p = mk(1'b1, 4'h4, 4'h4, 4'h8, 4'h5, 5'h0c, 5'h0c, 2'h0, 1'b0, 6'h20);
      5'h01: p = mk(1'b1, 4'h8, 4'h8, 4'h8, 4'h5, 5'h0c, 5'h0c, 2'h0, 1'b0, 6'h10);
      5'h02: p = mk(1'b0, 4'h4, 4'h4, 4'h8, 4'h5, 5'h0c, 5'h0c, 2'h0, 1'b0, 6'h20);
      5'h03: p = mk(1'b0, 4'h8, 4'h8, 4'h8, 4'h5, 5'h0c, 5'h0c, 2'h0, 1'b0, 6'h10);
      5'h05: p = mk(1'b1, 4'h4, 4'h1, 4'h1, 4'h4, 5'h08, 5'h08, 2'h0, 1'b0, 6'h14);
      5'h06: p = mk(1'b1, 4'h8, 4'h1, 4'h1, 4'h8, 5'h08, 5'h08, 2'h0, 1'b0, 6'h0a);
      5'h07: p = mk(1'b0, 4'h4, 4'h1, 4'h1, 4'h4, 5'h08, 5'h08, 2'h0, 1'b0, 6'h14);
      5'h08: p = mk(1'b0, 4'h8, 4'h1, 4'h1, 4'h8, 5'h08, 5'h08, 2'h0, 1'b0, 6'h0a);
      5'h0a: p = mk(1'b0, 4'h2, 4'h2, 4'h2, 4'h1, 5'h0f, 5'h10, 2'h1, 1'b0, 6'h28);
      5'h0b: p = mk(1'b0, 4'h4, 4'h2, 4'h2, 4'h2, 5'h0f, 5'h10, 2'h1, 1'b0, 6'h14);
      5'h0c: p = mk(1'b0, 4'h8, 4'h2, 4'h2, 4'h4, 5'h0f, 5'h10, 2'h1, 1'b0, 6'h0a);
      5'h0d: p = mk(1'b0, 4'h1, 4'h2, 4'h4, 4'h1, 5'h0f, 5'h10, 2'h1, 1'b0, 6'h28);
      5'h0e: p = mk(1'b0, 4'h2, 4'h2, 4'h2, 4'h1, 5'h0f, 5'h10, 2'h1, 1'b0, 6'h14);
      5'h0f: p = mk(1'b0, 4'h4, 4'h2, 4'h2, 4'h2, 5'h0f, 5'h10, 2'h1, 1'b0, 6'h0a);
      5'h10: p = mk(1'b0, 4'h8, 4'h2, 4'h2, 4'h4, 5'h0f, 5'h10, 2'h1, 1'b0, 6'h05);
      5'h13: p = mk(1'b1, 4'h6, 4'h1, 4'h2, 4'h8, 5'h0c, 5'h0c, 2'h0, 1'b1, 6'h14);
      5'h14: p = mk(1'b0, 4'h6, 4'h1, 4'h2, 4'h8, 5'h0c, 5'h0c, 2'h0, 1'b1, 6'h14);
      5'h15: p = mk(1'b1, 4'h2, 4'h1, 4'h2, 4'h2, 5'h0f, 5'h10, 2'h1, 1'b0, 6'h28);
      5'h16: p = mk(1'b1, 4'h4, 4'h1, 4'h2, 4'h4, 5'h0f, 5'h10, 2'h1, 1'b0, 6'h14);
      5'h17: p = mk(1'b1, 4'h1, 4'h1, 4'h2, 4'h1, 5'h0f, 5'h10, 2'h1, 1'b0, 6'h28);
      5'h18: p = mk(1'b1, 4'h2, 4'h1, 4'h2, 4'h2, 5'h0f, 5'h10, 2'h1, 1'b0, 6'h14);
      5'h19: p = mk(1'b1, 4'h8, 4'h1, 4'h2, 4'h8, 5'h0f, 5'h10, 2'h1, 1'b0, 6'h0a);
      5'h1a: p = mk(1'b1, 4'h4, 4'h1, 4'h2, 4'h4, 5'h0f, 5'h10, 2'h1, 1'b0, 6'h0a);
      default: p.bad = 1'b1;
    endcase
    return p;
  endfunction

  // Field values minus one, as carried on the link
  function automatic logic [7:0] m1(input logic [4:0] v);
    return {3'h0, v} - 8'h01;
  endfunction

  function automatic logic [7:0] ilas_octet(
    input jmipg_pkg::jmipg_prm_type p, input logic [7:0] km1,
    input logic [7:0] did, input logic scr, input logic [3:0] lid,
    input logic [3:0] idx);
    logic [7:0] o;
    logic [7:0] chk;
    logic [7:0] lm1;
    logic [7:0] nm1;
    logic [7:0] npm1;
    logic [7:0] sm1;
    lm1 = m1({1'b0, p.l});
    nm1 = m1(p.n);
    npm1 = m1(p.np);
    sm1 = m1({1'b0, p.s});
    chk = did + {4'h0, lid} + {7'h00, scr} + m1({1'b0, p.l})
      + m1({1'b0, p.f}) + km1 + m1({1'b0, p.m}) + m1(p.n)
      + {5'h00, jmipg_pkg::SUBCLASS_VAL} + m1(p.np)
      + {5'h00, jmipg_pkg::JESDV_VAL} + m1({1'b0, p.s});
    case (idx)
      4'h0: o = did;
      4'h2: o = {4'h0, lid};
      4'h3: o = {scr, 2'b00, lm1[4:0]};
      4'h4: o = m1({1'b0, p.f});
      4'h5: o = km1;
      4'h6: o = m1({1'b0, p.m});
      4'h7: o = {3'b000, nm1[4:0]};
      4'h8: o = {jmipg_pkg::SUBCLASS_VAL, npm1[4:0]};
      4'h9: o = {jmipg_pkg::JESDV_VAL, sm1[4:0]};
      4'hd: o = chk;
      default: o = 8'h00;
    endcase
    return o;
  endfunction

  jmipg_fifo #(
    .WIDTH($bits(jmipg_pkg::jmipg_word_type)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .ce(ce),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(f_in_data),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  assign f_in_valid = (r.st == jmipg_pkg::GEN_RUN) && r.link_en;
  assign f_in_data = '{lane: r.lane, idx: r.idx,
    octet: ilas_octet(r.l_prm, r.l_km1, r.l_did, r.l_scr, r.lane, r.idx)};
  // Output stage refills only when empty or taken
  assign f_out_ready = !r.ob_valid || ilas_ready;

  always_comb begin
    logic [31:0] rd;
    logic [4:0] lanes;
    logic [3:0] last_lane;
    rd = 32'h0000_0000;
    lanes = {r.l_prm.l, 1'b0};
    last_lane = 4'(lanes - 5'h01);
    n = r;

    n.prm = mode_table(r.mode);

    // Register read image
    case (r.dph_addr)
      jmipg_pkg::ADDR_MODE: rd = {27'h0, r.mode};
      jmipg_pkg::ADDR_KM1: rd = {24'h0, r.km1};
      jmipg_pkg::ADDR_DID: rd = {24'h0, r.did};
      jmipg_pkg::ADDR_CTRL: begin
        rd[jmipg_pkg::CTRL_EN_BIT] = r.link_en;
        rd[jmipg_pkg::CTRL_SCR_BIT] = r.scr_en;
        rd[jmipg_pkg::CTRL_SEL_LSB +: 2] = r.in_sel;
      end
      jmipg_pkg::ADDR_STAT: begin
        rd[jmipg_pkg::STAT_DES_BIT] = r.prm.des;
        rd[jmipg_pkg::STAT_BAD_BIT] = r.prm.bad;
        rd[jmipg_pkg::STAT_CAL_BIT] = r.cal_needed;
        rd[jmipg_pkg::STAT_BUSY_BIT] = r.st == jmipg_pkg::GEN_RUN;
        rd[jmipg_pkg::STAT_ENC_BIT] = r.prm.enc64;
        rd[jmipg_pkg::STAT_R_LSB +: 6] = r.prm.r8;
      end
      jmipg_pkg::ADDR_PRM0: rd = {r.prm.l, r.prm.m, r.prm.f, r.prm.s,
        3'h0, r.prm.n, 3'h0, r.prm.np};
      jmipg_pkg::ADDR_PRM1: rd = {r.prm.enc64 ? jmipg_pkg::E_VAL : 8'h00,
        6'h00, r.prm.links, 6'h00, r.prm.cs, 7'h00, r.prm.hd};
      default: rd = 32'h0000_0000;
    endcase

    // Data phase held one cycle so that read data comes from a flop
    if (r.dph) begin
      n.dph = 1'b0;
      n.hreadyout = 1'b1;
      if (r.dph_wr) begin
        case (r.dph_addr)
          jmipg_pkg::ADDR_MODE: n.mode = hwdata[4:0];
          jmipg_pkg::ADDR_KM1: n.km1 = hwdata[7:0];
          jmipg_pkg::ADDR_DID: n.did = hwdata[7:0];
          jmipg_pkg::ADDR_CTRL: begin
            n.link_en = hwdata[jmipg_pkg::CTRL_EN_BIT];
            n.scr_en = hwdata[jmipg_pkg::CTRL_SCR_BIT];
            n.in_sel = hwdata[jmipg_pkg::CTRL_SEL_LSB +: 2];
          end
          default: n.mode = r.mode;
        endcase
      end else begin
        n.hrdata = rd;
      end
    end
    if (hsel && htrans[1] && hready) begin
      n.dph = 1'b1;
      n.dph_wr = hwrite;
      n.dph_addr = (haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hff;
      n.hreadyout = 1'b0;
    end

    // Calibration flag set by any input select change; set wins over clear
    if (cal_done) begin
      n.cal_needed = 1'b0;
    end
    if (n.in_sel != r.in_sel) begin
      n.cal_needed = 1'b1;
    end

    // Parameters frozen at enable, held while the link is down
    case (r.st)
      jmipg_pkg::GEN_IDLE: begin
        if (r.link_en && !r.prm.bad) begin
          n.l_prm = r.prm;
          n.l_km1 = r.prm.enc64 ? 8'h00 : r.km1;
          n.l_did = r.did;
          n.l_scr = r.scr_en;
          n.lane = 4'h0;
          n.idx = 4'h0;
          n.st = r.prm.enc64 ? jmipg_pkg::GEN_DONE
            : jmipg_pkg::GEN_RUN;
        end
      end
      jmipg_pkg::GEN_RUN: begin
        if (!r.link_en) begin
          n.st = jmipg_pkg::GEN_IDLE;
        end else if (f_in_ready) begin
          if (r.idx == jmipg_pkg::ILAS_LAST_IDX) begin
            n.idx = 4'h0;
            if (r.lane == last_lane) begin
              n.st = jmipg_pkg::GEN_DONE;
            end else begin
              n.lane = r.lane + 4'h1;
            end
          end else begin
            n.idx = r.idx + 4'h1;
          end
        end
      end
      jmipg_pkg::GEN_DONE: begin
        if (!r.link_en) begin
          n.st = jmipg_pkg::GEN_IDLE;
        end
      end
      default: n.st = jmipg_pkg::GEN_IDLE;
    endcase

    if (f_out_ready) begin
      n.ob_valid = f_out_valid;
      n.ob_word = f_out_data;
    end

    // Same path for one or two inputs; only the pairing flag differs
    n.so_valid = smp_valid;
    if (smp_valid) begin
      n.so_data = {smp_b, smp_a};
      n.so_pair = r.prm.des;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      r <= '0;
      r.mode <= jmipg_pkg::MODE_RST;
      r.km1 <= jmipg_pkg::KM1_RST;
      r.did <= jmipg_pkg::DID_RST;
      r.hreadyout <= 1'b1;
    end else if (ce) begin
      r <= n;
    end
  end

  assign hrdata = r.hrdata;
  assign hreadyout = r.hreadyout;
  assign hresp = r.dph & 1'b0;
  assign smp_out = r.so_data;
  assign smp_out_valid = r.so_valid;
  assign smp_out_pair = r.so_pair;
  assign ilas_word = r.ob_word;
  assign ilas_valid = r.ob_valid;
  assign lane_rate_x8 = r.l_prm.r8;
  assign link_active = r.st == jmipg_pkg::GEN_DONE;

endmodule

// ===== tb/jmipg_props.sv
// Assertion checker for the link mode and alignment parameter generator
module jmipg_props (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [11:0] smp_a,
  input wire logic [11:0] smp_b,
  input wire logic smp_valid,
  input wire logic [23:0] smp_out,
  input wire logic smp_out_valid,
  input jmipg_pkg::jmipg_word_type ilas_word,
  input wire logic ilas_valid,
  input wire logic ilas_ready,
  input wire logic link_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic [9:0] sum_r;
  logic [9:0] sum_nxt;
  logic [7:0] o;
  logic [3:0] ix;
  logic take;
  assign o = ilas_word.octet;
  assign ix = ilas_word.idx;
  assign take = ilas_valid && ilas_ready && ce;
  // Sums field values: packed version bits must not count as octets
  always_comb begin
    sum_nxt = sum_r;
    if (take) begin
      sum_nxt = (ix == 4'h0) ? 10'h0 : sum_r;
      if (ix == 4'h3)
        sum_nxt = sum_nxt + o[7] + o[4:0];
      else if (ix == 4'h8 || ix == 4'h9)
        sum_nxt = sum_nxt + o[7:5] + o[4:0];
      else
        sum_nxt = sum_nxt + o;
    end
  end
  always_ff @(posedge clk_sys) begin
    sum_r <= !reset_n ? 10'h0 : sum_nxt;
  end
  property p_smp_data;
    $past(reset_n) && $past(ce) && $past(smp_valid)
      |-> smp_out == $past({smp_b, smp_a});
  endproperty
  property p_smp_valid;
    $past(reset_n) && $past(ce) |-> smp_out_valid == $past(smp_valid);
  endproperty
  property p_hold;
    ilas_valid && !(ilas_ready && ce) |=> ilas_valid && $stable(ilas_word);
  endproperty
  property p_zero;
    ilas_valid && (ix == 4'h1 || ix inside {[4'ha:4'hc]}) |-> o == 8'h0;
  endproperty
  property p_cs;
    ilas_valid && ix == 4'h7 |-> o[7:5] == 3'h0;
  endproperty
  property p_ver;
    ilas_valid && (ix == 4'h8 || ix == 4'h9) |-> o[7:5] == 3'h1;
  endproperty
  property p_lid;
    ilas_valid && ix == 4'h2 |-> o == {4'h0, ilas_word.lane};
  endproperty
  property p_sum;
    ilas_valid && ix == 4'hd |-> o == sum_r[7:0];
  endproperty
  a_smp_data: assert property (p_smp_data)
    else $error("sample pair not passed on");
  a_smp_valid: assert property (p_smp_valid)
    else $error("sample valid not passed on");
  a_hold: assert property (p_hold)
    else $error("octet changed before taken");
  a_zero: assert property (p_zero)
    else $error("fixed zero octet not zero");
  a_cs: assert property (p_cs)
    else $error("control bit field not zero");
  a_ver: assert property (p_ver)
    else $error("version field not one");
  a_lid: assert property (p_lid)
    else $error("lane identifier wrong");
  a_sum: assert property (p_sum)
    else $error("checksum wrong");
  c_last: cover property (take && ix == 4'hd);
  c_link: cover property ($rose(link_active));
  c_smp: cover property (smp_out_valid);
endmodule

bind jmipg_top jmipg_props u_props (.clk_sys, .reset_n, .ce, .smp_a,
  .smp_b, .smp_valid, .smp_out, .smp_out_valid, .ilas_word, .ilas_valid,
  .ilas_ready, .link_active);

// ===== tb/jmipg_rx_model.sv
// Receiver model that takes alignment octets promptly or with stalls
module jmipg_rx_model (
  input wire logic clk_sys,
  input wire logic ce,
  input jmipg_pkg::jmipg_word_type ilas_word,
  input wire logic ilas_valid,
  input wire logic slow,
  output logic ilas_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  jmipg_pkg::jmipg_word_type got [$];
  logic [2:0] cnt = 3'h0;
  initial ilas_ready = 1'b0;
  // Slow takes one word in eight, so the FIFO backs up to full
  always @(posedge clk_sys) begin
    if (ilas_valid && ilas_ready && ce)
      got.push_back(ilas_word);
    cnt <= cnt + 3'h1;
    ilas_ready <= !slow || cnt == 3'h0;
  end
endmodule

// ===== tb/tb_top.sv
// Register and alignment stream testbench for the parameter generator
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value at %0t ns: %h vs %h", $time, g, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, reset_n, ce, hsel, hwrite, hready, smp_valid, cal_done;
  logic hreadyout, hresp, smp_out_valid, smp_out_pair, ilas_valid;
  logic ilas_ready, link_active, slow;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [11:0] smp_a, smp_b;
  logic [23:0] smp_out;
  logic [5:0] lane_rate_x8;
  jmipg_pkg::jmipg_word_type ilas_word;
  int err_count, num_checks, cycles;
  logic [4:0] md [8] = '{0, 2, 5, 8, 13, 19, 4, 27};
  logic [31:0] st [8] = '{32'h2001, 32'h2000, 32'h1401, 32'h0a00,
    32'h2800, 32'h1401, 32'h2, 32'h2};
  logic [31:0] prm [6] = '{32'h44850c0c, 32'h44850c0c, 32'h41140808,
    32'h81180808, 32'h12410f10, 32'h61280c0c};
  assign hready = hreadyout;
  jmipg_top dut (.clk_sys, .reset_n, .ce, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .smp_a, .smp_b,
    .smp_valid, .smp_out, .smp_out_valid, .smp_out_pair, .cal_done,
    .ilas_word, .ilas_valid, .ilas_ready, .lane_rate_x8, .link_active);
  jmipg_rx_model rx (.clk_sys, .ce, .ilas_word, .ilas_valid, .slow,
    .ilas_ready);
  task give_verdict;
    if (err_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, e);
    xfer(1'b0, a, 32'h0);
    `CHK(rd & m, e)
  endtask
  function automatic logic [7:0] exp_oct(input logic [3:0] ln, ix,
    input logic [7:0] did, input logic scr);
    logic [7:0] f [13];
    f = '{did, 8'h0, {4'h0, ln}, {scr, 7'h0}, 8'h3, 8'h7, 8'h1, 8'he,
      8'h2f, 8'h20, 8'h0, 8'h0, 8'h0};
    return (ix == 4'hd) ? did + ln + scr + 8'h2a : f[ix];
  endfunction
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Cuts a hang short; the whole run needs well under this
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 20000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    logic [7:0] did;
    logic [15:0] ew;
    {reset_n, ce, hsel, hwrite, smp_valid, cal_done, slow} = 7'h20;
    {haddr, hwdata, htrans, hsize, smp_a, smp_b} = '0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    rchk(jmipg_pkg::ADDR_KM1, 32'hff, 32'h1f);
    rchk(8'h40, 32'hffffffff, 32'h0);
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, jmipg_pkg::ADDR_MODE, {27'h0, md[i]});
      rchk(jmipg_pkg::ADDR_STAT, i < 6 ? 32'h3f13 : 32'h2, st[i]);
      if (i < 6)
        rchk(jmipg_pkg::ADDR_PRM0, 32'hffffffff, prm[i]);
      smp_a <= 12'(i);
      smp_b <= ~12'(i);
      smp_valid <= 1'b1;
      @(posedge clk_sys);
      smp_valid <= 1'b0;
      #1;
      `CHK(smp_out, {~12'(i), 12'(i)})
      if (i < 6)
        `CHK(smp_out_pair, st[i][0])
      @(posedge clk_sys);
    end
    xfer(1'b1, jmipg_pkg::ADDR_MODE, 32'h0);
    xfer(1'b1, jmipg_pkg::ADDR_CTRL, 32'h30);
    rchk(jmipg_pkg::ADDR_STAT, 32'h3f17, 32'h2005);
    cal_done <= 1'b1;
    @(posedge clk_sys);
    cal_done <= 1'b0;
    rchk(jmipg_pkg::ADDR_STAT, 32'h3f17, 32'h2001);
    xfer(1'b1, jmipg_pkg::ADDR_MODE, 32'hd);
    xfer(1'b1, jmipg_pkg::ADDR_KM1, 32'h7);
    for (int r = 0; r < 2; r++) begin
      did = r == 0 ? 8'ha5 : 8'h3c;
      slow <= r == 0;
      rx.got.delete();
      xfer(1'b1, jmipg_pkg::ADDR_DID, {24'h0, did});
      xfer(1'b1, jmipg_pkg::ADDR_CTRL, {30'h0, r == 0, 1'b1});
      while (rx.got.size() < 28 || !link_active) @(posedge clk_sys);
      `CHK(lane_rate_x8, 6'h28)
      `CHK(rx.got.size(), 28)
      for (int k = 0; k < 28; k++) begin
        ew = {4'(k / 14), 4'(k % 14),
          exp_oct(4'(k / 14), 4'(k % 14), did, r == 0)};
        `CHK(rx.got[k], ew)
      end
      xfer(1'b1, jmipg_pkg::ADDR_CTRL, 32'h0);
      while (link_active) @(posedge clk_sys);
    end
    give_verdict();
  end
endmodule
